// ---- logic/sdcc_clock_control.sv ----
`timescale 1ns/1ps
// What this block does
// - bits 11..9 pick the first prescaler ratio 1, 3, 16 or 48, codes 1xx reserved.
// - bits 7..6 pick the second prescaler ratio 1, 2, 4 or 8.
// - bits 5..4 pick the converter clock source among main, sub-main, auxiliary and timer pin clocks.
// - with bit 8 clear the converter runs at normal full speed.
// - with bit 8 set the converter runs in reduced-speed reduced-power mode.
// - bit 3 turns the mid-voltage buffer on when set.
// - bit 2 turns the internal reference generator on when set.
// - an overflow interrupt is raised only with bit 1 and the global interrupt enable both set.
// - with bit 1 clear no overflow interrupt is requested.
// - bits 15..12 and bit 0 read zero and ignore writes, and writable fields reset to zero.
// - overflow is a new result arriving before the previous one was read.
module sdcc_clock_control
  import sdcc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // clock sources, asynchronous to clk
  input wire logic mainClock,
  input wire logic subMainClock,
  input wire logic auxClock,
  input wire logic timerExternalClockPin,
  // converter side
  input wire logic globalIrqEnable,
  input wire logic resultValid,
  input wire logic [15:0] resultData,
  output logic convClockEnable,
  output logic lowPowerSpeedSel,
  output logic midVoltageBufferOn,
  output logic referenceGeneratorOn,
  output logic overflowIrq
);
  sdcc_state_t s_q;
  sdcc_state_t s_d;
  logic [3:0] srcRaw;
  logic srcSel;
  logic srcRise;
  logic [5:0] div1;
  logic [2:0] div2Max;
  logic access;
  logic [31:0] rdMux;

  assign srcRaw = {timerExternalClockPin, auxClock, subMainClock, mainClock};
  assign access = cyc_i && stb_i && !s_q.wb.ack;

  // source levels cross into clk through two flops each, all four kept live; switching from a low source to a high one counts as a source edge
  always_comb begin
    srcSel = 1'b0;
    case (s_q.ctrl.clockSourceSel)
      2'h0: srcSel = s_q.srcSync2[0];
      2'h1: srcSel = s_q.srcSync2[1];
      2'h2: srcSel = s_q.srcSync2[2];
      2'h3: srcSel = s_q.srcSync2[3];
      default: srcSel = 1'b0;
    endcase
    div1 = FIRST_DIV_1;
    case (s_q.ctrl.firstPrescalerSel)
      3'h0: div1 = FIRST_DIV_1;
      3'h1: div1 = FIRST_DIV_3;
      3'h2: div1 = FIRST_DIV_16;
      3'h3: div1 = FIRST_DIV_48;
      // reserved codes fall back to divide by one
      default: div1 = FIRST_DIV_1;
    endcase
    div2Max = 3'((4'h1 << s_q.ctrl.secondPrescalerSel) - 4'h1);
  end
  assign srcRise = srcSel && !s_q.srcPrev;

  always_comb begin
    rdMux = 32'h0000_0000;
    case (adr_i)
      ADDR_GLOBAL_CTRL: rdMux = {16'h0000, 4'h0, s_q.ctrl, 1'b0};
      ADDR_STATUS: rdMux = {30'h0, s_q.resultUnread, s_q.overflowFlag};
      ADDR_RESULT: rdMux = {16'h0000, s_q.result};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // only the second stage is read, the first may be metastable
    s_d.srcSync1 = srcRaw;
    s_d.srcSync2 = s_q.srcSync1;
    s_d.srcPrev = srcSel;
    // prescalers in series: stage two counts stage one ticks
    s_d.tick1 = 1'b0;
    s_d.convClkEn = 1'b0;
    if (srcRise) begin
      if (s_q.cnt1 >= div1 - 6'h01) begin
        s_d.cnt1 = 6'h00;
        s_d.tick1 = 1'b1;
      end else begin
        s_d.cnt1 = s_q.cnt1 + 6'h01;
      end
    end
    if (s_q.tick1) begin
      if (s_q.cnt2 >= div2Max) begin
        s_d.cnt2 = 3'h0;
        s_d.convClkEn = 1'b1;
      end else begin
        s_d.cnt2 = s_q.cnt2 + 3'h1;
      end
    end
    // wishbone: one wait state, ack for one cycle
    s_d.wb.ack = access;
    s_d.wb.rdat = access ? rdMux : s_q.wb.rdat;
    if (access && we_i && adr_i == ADDR_GLOBAL_CTRL) begin
      if (sel_i[0]) begin
        s_d.ctrl.secondPrescalerSel = dat_i[SECOND_PRESC_LSB +: 2];
        s_d.ctrl.clockSourceSel = dat_i[CLK_SRC_LSB +: 2];
        s_d.ctrl.midVoltageBufferOn = dat_i[MID_BUF_BIT];
        s_d.ctrl.referenceGeneratorOn = dat_i[REF_ON_BIT];
        s_d.ctrl.overflowIrqEnable = dat_i[OVF_IE_BIT];
      end
      if (sel_i[1]) begin
        s_d.ctrl.firstPrescalerSel = dat_i[FIRST_PRESC_LSB +: 3];
        s_d.ctrl.lowPowerSpeedSel = dat_i[LOW_POWER_BIT];
      end
    end
    // reading the result marks it consumed; a same-cycle new result still counts as unread
    if (access && !we_i && adr_i == ADDR_RESULT) begin
      s_d.resultUnread = 1'b0;
    end
    // software clears the overflow flag by writing one; a new overflow wins
    if (access && we_i && adr_i == ADDR_STATUS && sel_i[0] && dat_i[STAT_OVF_BIT]) begin
      s_d.overflowFlag = 1'b0;
    end
    if (resultValid) begin
      s_d.result = resultData;
      s_d.resultUnread = 1'b1;
      if (s_q.resultUnread) begin
        s_d.overflowFlag = 1'b1;
      end
    end
    s_d.irq = s_q.overflowFlag && s_q.ctrl.overflowIrqEnable && globalIrqEnable;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dat_o = s_q.wb.rdat;
  assign ack_o = s_q.wb.ack;
  assign convClockEnable = s_q.convClkEn;
  assign lowPowerSpeedSel = s_q.ctrl.lowPowerSpeedSel;
  assign midVoltageBufferOn = s_q.ctrl.midVoltageBufferOn;
  assign referenceGeneratorOn = s_q.ctrl.referenceGeneratorOn;
  assign overflowIrq = s_q.irq;

  property p_irq_gate;
    @(posedge clk) disable iff (!nrst)
    overflowIrq |-> $past(s_q.ctrl.overflowIrqEnable) && $past(globalIrqEnable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without both enables");

  property p_irq_off;
    @(posedge clk) disable iff (!nrst)
    !s_q.ctrl.overflowIrqEnable [*2] |-> !overflowIrq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while enable clear");

  property p_irq_on;
    @(posedge clk) disable iff (!nrst)
    s_q.overflowFlag && s_q.ctrl.overflowIrqEnable && globalIrqEnable |=> overflowIrq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  property p_ovf_set;
    @(posedge clk) disable iff (!nrst)
    resultValid && s_q.resultUnread |=> s_q.overflowFlag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

  property p_ovf_cause;
    @(posedge clk) disable iff (!nrst)
    $rose(s_q.overflowFlag) |-> $past(resultValid) && $past(s_q.resultUnread);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("spurious overflow");

  property p_reserved;
    @(posedge clk) disable iff (!nrst)
    ack_o && $past(adr_i) == ADDR_GLOBAL_CTRL |-> dat_o[31:12] == 20'h0 && !dat_o[0];
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

  property p_ctrl_write;
    @(posedge clk) disable iff (!nrst)
    access && we_i && adr_i == ADDR_GLOBAL_CTRL && sel_i[1] |=> lowPowerSpeedSel == $past(dat_i[LOW_POWER_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("low power bit not written");

  property p_ref_write;
    @(posedge clk) disable iff (!nrst)
    access && we_i && adr_i == ADDR_GLOBAL_CTRL && sel_i[0]
      |=> referenceGeneratorOn == $past(dat_i[REF_ON_BIT]) && midVoltageBufferOn == $past(dat_i[MID_BUF_BIT]);
  endproperty
  a_ref_write: assert property (p_ref_write) else $error("analog enables not written");

  property p_div_single;
    @(posedge clk) disable iff (!nrst)
    convClockEnable |=> !convClockEnable;
  endproperty
  a_div_single: assert property (p_div_single) else $error("enable wider than one cycle");

  property p_ack_pulse;
    @(posedge clk) disable iff (!nrst)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack timing");

  // field writes land one cycle after the taken request
  property p_first_write;
    @(posedge clk) disable iff (!nrst)
    access && we_i && adr_i == ADDR_GLOBAL_CTRL && sel_i[1]
      |=> s_q.ctrl.firstPrescalerSel == $past(dat_i[FIRST_PRESC_LSB +: 3]);
  endproperty
  a_first_write: assert property (p_first_write) else $error("first prescaler not written");

  property p_second_write;
    @(posedge clk) disable iff (!nrst)
    access && we_i && adr_i == ADDR_GLOBAL_CTRL && sel_i[0]
      |=> s_q.ctrl.secondPrescalerSel == $past(dat_i[SECOND_PRESC_LSB +: 2]);
  endproperty
  a_second_write: assert property (p_second_write) else $error("second prescaler not written");

  property p_src_write;
    @(posedge clk) disable iff (!nrst)
    access && we_i && adr_i == ADDR_GLOBAL_CTRL && sel_i[0]
      |=> s_q.ctrl.clockSourceSel == $past(dat_i[CLK_SRC_LSB +: 2]);
  endproperty
  a_src_write: assert property (p_src_write) else $error("clock source not written");

  property p_ovfie_write;
    @(posedge clk) disable iff (!nrst)
    access && we_i && adr_i == ADDR_GLOBAL_CTRL && sel_i[0]
      |=> s_q.ctrl.overflowIrqEnable == $past(dat_i[OVF_IE_BIT]);
  endproperty
  a_ovfie_write: assert property (p_ovfie_write) else $error("overflow enable not written");

  property p_ctrl_hold;
    @(posedge clk) disable iff (!nrst)
    !(access && we_i && adr_i == ADDR_GLOBAL_CTRL) |=> s_q.ctrl == $past(s_q.ctrl);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed without write");

  // unmapped addresses answer with zero data
  property p_unmapped_read;
    @(posedge clk) disable iff (!nrst)
    ack_o && $past(adr_i) != ADDR_GLOBAL_CTRL && $past(adr_i) != ADDR_STATUS && $past(adr_i) != ADDR_RESULT
      |-> dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read nonzero");

  property p_status_read;
    @(posedge clk) disable iff (!nrst)
    ack_o && $past(adr_i) == ADDR_STATUS |-> dat_o[31:2] == 30'h0;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status upper bits nonzero");

  // prescaler chain only advances on synchronised source edges
  property p_tick_rise;
    @(posedge clk) disable iff (!nrst)
    s_q.tick1 |-> $past(srcRise);
  endproperty
  a_tick_rise: assert property (p_tick_rise) else $error("stage one tick without source edge");

  property p_cce_tick;
    @(posedge clk) disable iff (!nrst)
    convClockEnable |-> $past(s_q.tick1);
  endproperty
  a_cce_tick: assert property (p_cce_tick) else $error("enable without stage one tick");

  property p_div1_bound;
    @(posedge clk) disable iff (!nrst)
    s_q.cnt1 <= 6'h2f;
  endproperty
  a_div1_bound: assert property (p_div1_bound) else $error("first counter out of range");

  // reserved first prescaler codes behave as divide by one
  property p_div1_one;
    @(posedge clk) disable iff (!nrst)
    srcRise && (s_q.ctrl.firstPrescalerSel == 3'h0 || s_q.ctrl.firstPrescalerSel[2]) |=> s_q.tick1;
  endproperty
  a_div1_one: assert property (p_div1_one) else $error("divide by one missed a tick");

  property p_cnt1_hold;
    @(posedge clk) disable iff (!nrst)
    !srcRise |=> s_q.cnt1 == $past(s_q.cnt1);
  endproperty
  a_cnt1_hold: assert property (p_cnt1_hold) else $error("first counter moved without edge");

  property p_div2_one;
    @(posedge clk) disable iff (!nrst)
    s_q.tick1 && s_q.ctrl.secondPrescalerSel == 2'h0 |=> convClockEnable;
  endproperty
  a_div2_one: assert property (p_div2_one) else $error("second divide by one missed");

  property p_cnt2_hold;
    @(posedge clk) disable iff (!nrst)
    !s_q.tick1 |=> s_q.cnt2 == $past(s_q.cnt2);
  endproperty
  a_cnt2_hold: assert property (p_cnt2_hold) else $error("second counter moved without tick");

  property p_irq_flag;
    @(posedge clk) disable iff (!nrst)
    overflowIrq |-> $past(s_q.overflowFlag);
  endproperty
  a_irq_flag: assert property (p_irq_flag) else $error("irq without overflow");

  // a fresh overflow in the clearing cycle keeps the flag
  property p_ovf_clear;
    @(posedge clk) disable iff (!nrst)
    access && we_i && adr_i == ADDR_STATUS && sel_i[0] && dat_i[STAT_OVF_BIT] && !(resultValid && s_q.resultUnread)
      |=> !s_q.overflowFlag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

  property p_ovf_hold;
    @(posedge clk) disable iff (!nrst)
    s_q.overflowFlag && !(access && we_i && adr_i == ADDR_STATUS) |=> s_q.overflowFlag;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow lost");

  property p_unread_set;
    @(posedge clk) disable iff (!nrst)
    resultValid |=> s_q.resultUnread && s_q.result == $past(resultData);
  endproperty
  a_unread_set: assert property (p_unread_set) else $error("result not captured");

  property p_result_read;
    @(posedge clk) disable iff (!nrst)
    access && !we_i && adr_i == ADDR_RESULT && !resultValid |=> !s_q.resultUnread;
  endproperty
  a_result_read: assert property (p_result_read) else $error("read did not consume result");
endmodule

// ---- logic/sdcc_pkg.sv ----
package sdcc_pkg;
  // register map, byte addresses on the wishbone bus
  localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  // field positions in the global control register
  localparam int FIRST_PRESC_LSB = 9;
  localparam int LOW_POWER_BIT = 8;
  localparam int SECOND_PRESC_LSB = 6;
  localparam int CLK_SRC_LSB = 4;
  localparam int MID_BUF_BIT = 3;
  localparam int REF_ON_BIT = 2;
  localparam int OVF_IE_BIT = 1;
  // status register bits
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h0ffe;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // first prescaler ratios
  localparam logic [5:0] FIRST_DIV_1 = 6'h01;
  localparam logic [5:0] FIRST_DIV_3 = 6'h03;
  localparam logic [5:0] FIRST_DIV_16 = 6'h10;
  localparam logic [5:0] FIRST_DIV_48 = 6'h30;

  typedef struct packed {
    logic [2:0] firstPrescalerSel;
    logic lowPowerSpeedSel;
    logic [1:0] secondPrescalerSel;
    logic [1:0] clockSourceSel;
    logic midVoltageBufferOn;
    logic referenceGeneratorOn;
    logic overflowIrqEnable;
  } sdcc_ctrl_t;

  typedef struct packed {
    logic [31:0] rdat;
    logic ack;
  } sdcc_wbout_t;

  typedef struct packed {
    sdcc_ctrl_t ctrl;
    sdcc_wbout_t wb;
    logic [15:0] result;
    logic resultUnread;
    logic overflowFlag;
    logic irq;
    logic [3:0] srcSync1;
    logic [3:0] srcSync2;
    logic srcPrev;
    logic [5:0] cnt1;
    logic tick1;
    logic [2:0] cnt2;
    logic convClkEn;
  } sdcc_state_t;
endpackage

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import sdcc_pkg::*;
;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, global_irq_enable = 0, rv = 0, ack, cce, lp, mb, rf, irq;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rdat, r;
  logic [15:0] rd = 0;
  logic [3:0] src = 0;
  int cnt = 0, mismatches = 0, compares = 0, ctrlM = 0, flag = 0, unread = 0, last = 0;
  always #10 clk = ~clk;
  // source clocks well below clk/2
  always @(posedge clk) begin
    cnt <= cnt + 1;
    src <= {1'((cnt / 5) % 2), 1'((cnt / 4) % 2), 1'((cnt / 3) % 2), 1'((cnt / 2) % 2)};
  end
  sdcc_clock_control i_sdcc_clock_control (.clk(clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .mainClock(src[0]),
    .subMainClock(src[1]), .auxClock(src[2]), .timerExternalClockPin(src[3]), .globalIrqEnable(global_irq_enable),
    .resultValid(rv), .resultData(rd), .convClockEnable(cce), .lowPowerSpeedSel(lp),
    .midVoltageBufferOn(mb), .referenceGeneratorOn(rf), .overflowIrq(irq));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 0; stb <= 0; we <= 0; sel <= 0;
    chk("ack", 1, ack);
  endtask
  task automatic wctl(input int v);
    wb(1, ADDR_GLOBAL_CTRL, v);
    ctrlM = v & 32'h0ffe;
  endtask
  task automatic res(input logic [15:0] d);
    @(posedge clk);
    rv <= 1; rd <= d;
    @(posedge clk);
    rv <= 0;
    if (unread) flag = 1;
    unread = 1; last = d;
    repeat (4) @(posedge clk);
  endtask
  task automatic irqchk();
    repeat (3) @(posedge clk);
    chk("overflowIrq", flag & ctrlM[OVF_IE_BIT] & global_irq_enable, irq);
  endtask
  // source edges between two steady enable pulses must equal the ratio product
  task automatic period(input int s, input int e);
    int n, k, p;
    n = 0;
    k = 0;
    p = src[s];
    while (k < 3 && n < 20000) begin
      @(posedge clk);
      n++;
      if (cce === 1'b1) begin
        k++;
        if (k == 2) n = 0;
      end
      if (k == 2 && src[s] === 1'b1 && p == 0) n = n;
    end
    chk("cceTimeout", 0, n >= 20000);
    n = 0;
    k = 0;
    p = src[s];
    while (k < 1 && n < 20000) begin
      @(posedge clk);
      if (src[s] === 1'b1 && p == 0) n++;
      p = src[s];
      if (cce === 1'b1) k++;
    end
    chk("divEdges", e, n);
  endtask
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1600000;
    mismatches++;
    finish_test();
  end
  initial begin
    int v, d1, d2;
    void'($urandom(32'h69e00ae9));
    repeat (16) @(posedge clk);
    nrst <= 1;
    wb(0, ADDR_GLOBAL_CTRL, 0);
    chk("ctrlReset", 0, r);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wctl(v);
      wb(0, ADDR_GLOBAL_CTRL, 0);
      chk("ctrlRead", ctrlM, r);
      chk("lowPower", ctrlM[LOW_POWER_BIT], lp);
      chk("midBuf", ctrlM[MID_BUF_BIT], mb);
      chk("refOn", ctrlM[REF_ON_BIT], rf);
    end
    wb(1, 8'h3c, 32'hffff);
    wb(0, 8'h3c, 0);
    chk("unmapped", 0, r);
    for (int i = 0; i < 5; i++) begin
      d2 = $urandom_range(3);
      wctl((i << FIRST_PRESC_LSB) | (d2 << SECOND_PRESC_LSB) | ((i % 4) << CLK_SRC_LSB));
      d1 = (i == 1) ? 3 : (i == 2) ? 16 : (i == 3) ? 48 : 1;
      period(i % 4, d1 * (1 << d2));
    end
    global_irq_enable <= 1;
    wctl(32'h0002);
    res(16'h1111);
    irqchk();
    res(16'h2222);
    irqchk();
    global_irq_enable <= 0;
    irqchk();
    global_irq_enable <= 1;
    wctl(0);
    irqchk();
    wctl(32'h0002);
    irqchk();
    wb(0, ADDR_RESULT, 0);
    chk("result", last, r[15:0]);
    unread = 0;
    wb(1, ADDR_STATUS, 32'h1);
    flag = 0;
    wb(0, ADDR_STATUS, 0);
    chk("status", {unread[0], flag[0]}, r[1:0]);
    irqchk();
    res(16'($urandom));
    wb(0, ADDR_RESULT, 0);
    unread = 0;
    res(16'h3333);
    irqchk();
    finish_test();
  end
endmodule
